/* fsag_pkg.sv */
package fsag_pkg;

  // ------------------------------------------------------------------
  // Register map and reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] PROGRAM_STORE_CONTROL_ADDR = 8'h8f;
  localparam logic [7:0] PROGRAM_STORE_CONTROL_RST = 8'h00;
  localparam int WRITE_ENABLE_BIT = 0;
  localparam int ERASE_ENABLE_BIT = 1;
  localparam int SCRATCH_SEL_BIT = 2;
  localparam logic [15:0] ACCESS_LIMIT_RST = 16'h0000;

  // ------------------------------------------------------------------
  // Flash geometry
  // ------------------------------------------------------------------
  localparam logic [15:0] LOCK_WE_ADDR_64K = 16'hfbfe;
  localparam logic [15:0] LOCK_RD_ADDR_64K = 16'hfbff;
  localparam logic [15:0] LOCK_WE_ADDR_32K = 16'h7ffe;
  localparam logic [15:0] LOCK_RD_ADDR_32K = 16'h7fff;
  localparam int LOCK_PAGE_BIT_64K = 7;
  localparam int LOCK_PAGE_BIT_32K = 3;
  localparam int BLOCK_SHIFT = 13;
  localparam int PAGE_SHIFT = 9;
  localparam logic [15:0] SCRATCH_MASK = 16'h007f;
  localparam logic [15:0] RESERVED_BASE_64K = 16'hfc00;
  localparam logic [15:0] RESERVED_BASE_32K = 16'h8000;
  localparam logic [7:0] LOCK_UNLOCKED = 8'hff;

  // ------------------------------------------------------------------
  // Access carriers
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    FSAG_OP_READ = 2'h0,
    FSAG_OP_WRITE = 2'h1,
    FSAG_OP_ERASE = 2'h2
  } fsag_op_e;

  typedef struct packed {
    logic valid;
    fsag_op_e op;
    logic [15:0] addr;
    logic [7:0] data;
  } fsag_req_s;

  typedef struct packed {
    logic valid;
    logic code_read;
    logic [15:0] pc;
    logic write;
    logic [15:0] addr;
    logic [7:0] data;
  } fsag_cpu_s;

  typedef enum logic [2:0] {
    FSAG_CMD_NONE = 3'h0,
    FSAG_CMD_PROGRAM = 3'h1,
    FSAG_CMD_PAGE_ERASE = 3'h2,
    FSAG_CMD_FULL_ERASE = 3'h4
  } fsag_cmd_e;

  typedef struct packed {
    fsag_cmd_e cmd;
    logic scratch;
    logic [15:0] addr;
    logic [7:0] data;
  } fsag_flash_s;

endpackage

/* fsag_guard.sv */
`timescale 1ns/1ps
module fsag_guard #(
  parameter bit SIZE_64K = 1'b1
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic limit_wr,
  input wire logic [15:0] limit_wdata,
  input wire fsag_pkg::fsag_req_s dbg_req,
  input wire fsag_pkg::fsag_cpu_s cpu_req,
  input wire logic [7:0] flash_rdata,
  input wire logic [7:0] lock_we_byte,
  input wire logic [7:0] lock_rd_byte,
  output logic [7:0] program_store_control,
  output logic [15:0] access_limit_address,
  output fsag_pkg::fsag_flash_s flash_cmd,
  output logic [7:0] dbg_rdata,
  output logic dbg_done,
  output logic dbg_denied,
  output logic cpu_done,
  output logic cpu_denied,
  output logic cpu_ram_write,
  output logic [7:0] cpu_rdata
);

  // ------------------------------------------------------------------
  // Address classification
  // ------------------------------------------------------------------
  function automatic logic is_lock_byte(input logic [15:0] a);
    if (SIZE_64K) begin
      return (a == fsag_pkg::LOCK_WE_ADDR_64K) || (a == fsag_pkg::LOCK_RD_ADDR_64K);
    end else begin
      return (a == fsag_pkg::LOCK_WE_ADDR_32K) || (a == fsag_pkg::LOCK_RD_ADDR_32K);
    end
  endfunction

  function automatic logic is_lock_page(input logic [15:0] a);
    logic [15:0] la;
    la = SIZE_64K ? fsag_pkg::LOCK_WE_ADDR_64K : fsag_pkg::LOCK_WE_ADDR_32K;
    return a[15:fsag_pkg::PAGE_SHIFT] == la[15:fsag_pkg::PAGE_SHIFT];
  endfunction

  function automatic logic is_reserved(input logic [15:0] a);
    return a >= (SIZE_64K ? fsag_pkg::RESERVED_BASE_64K : fsag_pkg::RESERVED_BASE_32K);
  endfunction

  // Lock bit for a block; a zero bit means locked.
  function automatic logic block_open(input logic [7:0] lb, input logic [15:0] a);
    return lb[a[15:fsag_pkg::BLOCK_SHIFT]];
  endfunction

  // ------------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------------
  logic [2:0] ctl_ff;
  logic [15:0] limit_ff;
  wire ctl_sel = sfr_wr && (sfr_addr == fsag_pkg::PROGRAM_STORE_CONTROL_ADDR);
  wire [2:0] nxt_ctl = ctl_sel ? sfr_wdata[2:0] : ctl_ff;
  wire [15:0] nxt_limit = limit_wr ? limit_wdata : limit_ff;
  wire wr_en = ctl_ff[fsag_pkg::WRITE_ENABLE_BIT];
  wire er_en = ctl_ff[fsag_pkg::ERASE_ENABLE_BIT];
  wire sc_sel = ctl_ff[fsag_pkg::SCRATCH_SEL_BIT];

  // Only the three low control bits are stored; the upper bits always read zero.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ctl_ff <= fsag_pkg::PROGRAM_STORE_CONTROL_RST[2:0];
    end else begin
      ctl_ff <= nxt_ctl;
    end
  end

  // The access limit splits firmware into an upper and a lower partition.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      limit_ff <= fsag_pkg::ACCESS_LIMIT_RST;
    end else begin
      limit_ff <= nxt_limit;
    end
  end

  // ------------------------------------------------------------------
  // Debug-port decision
  // ------------------------------------------------------------------
  wire [15:0] d_addr = dbg_req.addr;
  wire lock_page_bit = SIZE_64K ? lock_we_byte[fsag_pkg::LOCK_PAGE_BIT_64K]
                                : lock_we_byte[fsag_pkg::LOCK_PAGE_BIT_32K];
  wire lock_page_locked = !lock_page_bit;
  wire d_is_lock = is_lock_byte(d_addr);
  wire d_rd_open = block_open(lock_rd_byte, d_addr);
  wire d_we_open = block_open(lock_we_byte, d_addr);
  wire d_read = dbg_req.valid && (dbg_req.op == fsag_pkg::FSAG_OP_READ);
  wire d_write = dbg_req.valid && (dbg_req.op == fsag_pkg::FSAG_OP_WRITE);
  wire d_erase = dbg_req.valid && (dbg_req.op == fsag_pkg::FSAG_OP_ERASE);
  wire d_resv = is_reserved(d_addr);
  wire d_rd_ok = d_read && !d_resv && (d_is_lock || d_rd_open);
  wire d_wr_ok = d_write && !d_resv && (d_we_open || (d_is_lock && lock_page_locked));
  wire d_full = d_erase && d_is_lock && lock_page_locked;
  wire d_pg_ok = d_erase && !d_resv && !d_full && d_we_open;
  wire d_ok = d_rd_ok || d_wr_ok || d_full || d_pg_ok;

  // A locked lock page cannot be page erased over the debug port.
  // An erase aimed at a lock byte then becomes a full device erase instead.
  // Writes to the lock bytes stay open so further blocks can be locked later.

  // Scratchpad lock state, usable when a scratch access path is wired.
  wire scratch_rd_locked = (lock_rd_byte == 8'h00);
  wire scratch_we_locked = (lock_we_byte == 8'h00);

  // ------------------------------------------------------------------
  // Firmware decision
  // ------------------------------------------------------------------
  wire [15:0] c_addr = sc_sel ? (cpu_req.addr & fsag_pkg::SCRATCH_MASK) : cpu_req.addr;
  // Data and code-read requests are both checked; branches are not requests and never blocked.
  wire c_upper = cpu_req.pc >= limit_ff;
  wire c_below = !sc_sel && (c_addr < limit_ff);
  wire c_part_bad = c_upper && c_below;
  wire c_resv = !sc_sel && is_reserved(c_addr);
  wire c_wr = cpu_req.valid && cpu_req.write && !cpu_req.code_read;
  wire c_rd = cpu_req.valid && !cpu_req.write;
  wire c_ram = c_wr && !wr_en;
  wire c_erase = c_wr && wr_en && er_en;
  wire c_lockpg = !sc_sel && is_lock_page(c_addr);
  wire c_er_ok = c_erase && !c_part_bad && !c_resv && !c_lockpg;
  wire c_pg_ok = c_wr && wr_en && !er_en && !c_part_bad && !c_resv;
  wire c_rd_ok = c_rd && !c_part_bad && !c_resv;
  wire c_ok = c_er_ok || c_pg_ok || c_rd_ok || c_ram;

  // The lock bytes play no part here: they guard the debug port only.
  // The scratchpad lies outside the partition and reserved checks.

  // ------------------------------------------------------------------
  // Command to the flash engine, debug port first
  // ------------------------------------------------------------------
  // The debug port wins when both requesters ask in the same cycle.
  // The firmware request is then dropped and reports no completion.
  fsag_pkg::fsag_flash_s nxt_cmd;
  always_comb begin
    nxt_cmd.cmd = fsag_pkg::FSAG_CMD_NONE;
    nxt_cmd.scratch = 1'b0;
    nxt_cmd.addr = d_addr;
    nxt_cmd.data = dbg_req.data;
    if (dbg_req.valid) begin
      if (d_full) begin
        nxt_cmd.cmd = fsag_pkg::FSAG_CMD_FULL_ERASE;
      end else if (d_pg_ok) begin
        nxt_cmd.cmd = fsag_pkg::FSAG_CMD_PAGE_ERASE;
      end else if (d_wr_ok) begin
        nxt_cmd.cmd = fsag_pkg::FSAG_CMD_PROGRAM;
      end
    end else begin
      nxt_cmd.addr = c_addr;
      nxt_cmd.data = cpu_req.data;
      nxt_cmd.scratch = sc_sel;
      if (c_er_ok) begin
        nxt_cmd.cmd = fsag_pkg::FSAG_CMD_PAGE_ERASE;
      end else if (c_pg_ok) begin
        nxt_cmd.cmd = fsag_pkg::FSAG_CMD_PROGRAM;
      end
    end
  end

  wire [7:0] nxt_dbg_rdata = d_rd_ok ? flash_rdata : 8'h00;
  wire cpu_go = cpu_req.valid && !dbg_req.valid;
  wire [7:0] nxt_cpu_rdata = (cpu_go && c_rd_ok) ? flash_rdata : 8'h00;
  wire nxt_dbg_denied = dbg_req.valid && !d_ok;
  wire nxt_cpu_denied = cpu_go && !c_ok;
  wire nxt_cpu_ram_write = cpu_go && c_ram;
  wire [7:0] nxt_psc = {5'h00, nxt_ctl};

  // ------------------------------------------------------------------
  // Flash command register
  // ------------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      flash_cmd <= '0;
    end else begin
      flash_cmd <= nxt_cmd;
    end
  end

  // ------------------------------------------------------------------
  // Debug-port answer
  // ------------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      dbg_rdata <= 8'h00;
    end else begin
      dbg_rdata <= nxt_dbg_rdata;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      dbg_done <= 1'b0;
    end else begin
      dbg_done <= dbg_req.valid;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      dbg_denied <= 1'b0;
    end else begin
      dbg_denied <= nxt_dbg_denied;
    end
  end

  // ------------------------------------------------------------------
  // Firmware answer
  // ------------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cpu_done <= 1'b0;
    end else begin
      cpu_done <= cpu_go;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cpu_denied <= 1'b0;
    end else begin
      cpu_denied <= nxt_cpu_denied;
    end
  end

  // A data-move write with write enable off goes to external RAM.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cpu_ram_write <= 1'b0;
    end else begin
      cpu_ram_write <= nxt_cpu_ram_write;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cpu_rdata <= 8'h00;
    end else begin
      cpu_rdata <= nxt_cpu_rdata;
    end
  end

  // ------------------------------------------------------------------
  // Register copies
  // ------------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      program_store_control <= fsag_pkg::PROGRAM_STORE_CONTROL_RST;
    end else begin
      program_store_control <= nxt_psc;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      access_limit_address <= fsag_pkg::ACCESS_LIMIT_RST;
    end else begin
      access_limit_address <= nxt_limit;
    end
  end

  // Scratch lock flags are held for a future scratch debug path.
  wire unused_scratch = scratch_rd_locked ^ scratch_we_locked;

endmodule

/* fsag_guard_monitor.sv */
`timescale 1ns/1ps
module fsag_guard_monitor (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire fsag_pkg::fsag_req_s dbg_req,
  input wire fsag_pkg::fsag_cpu_s cpu_req,
  input wire logic [7:0] lock_we_byte,
  input wire logic [7:0] lock_rd_byte,
  input wire logic [7:0] program_store_control,
  input wire logic [15:0] access_limit_address,
  input wire fsag_pkg::fsag_flash_s flash_cmd,
  input wire logic [7:0] dbg_rdata,
  input wire logic dbg_denied,
  input wire logic cpu_denied,
  input wire logic cpu_ram_write
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  wire dr = dbg_req.valid && dbg_req.op == fsag_pkg::FSAG_OP_READ;
  wire dw = dbg_req.valid && dbg_req.op == fsag_pkg::FSAG_OP_WRITE;
  wire de = dbg_req.valid && dbg_req.op == fsag_pkg::FSAG_OP_ERASE;
  wire cv = cpu_req.valid && !dbg_req.valid;
  wire cw = cv && cpu_req.write;
  wire lk = dbg_req.addr[15:1] == 15'h7dff;
  wire [2:0] blk = dbg_req.addr[15:13];
  ctl_write_a: assert property (sfr_wr && sfr_addr == 8'h8f |=>
    program_store_control == {5'h00, $past(sfr_wdata[2:0])}) else $error("control bad");
  rd_lock_a: assert property (dr && !lk && dbg_req.addr < 16'hfc00 && !lock_rd_byte[blk]
    |=> dbg_denied && dbg_rdata == 8'h00) else $error("locked read passed");
  lock_read_a: assert property (dr && lk |=> !dbg_denied) else $error("lock read denied");
  wr_lock_a: assert property (dw && !lk && !lock_we_byte[blk]
    |=> dbg_denied && flash_cmd.cmd == fsag_pkg::FSAG_CMD_NONE) else $error("locked write");
  full_erase_a: assert property (de && lk && !lock_we_byte[7]
    |=> flash_cmd.cmd == fsag_pkg::FSAG_CMD_FULL_ERASE) else $error("no full erase");
  fw_full_a: assert property (flash_cmd.cmd == fsag_pkg::FSAG_CMD_FULL_ERASE
    |-> $past(de)) else $error("full erase not from debug");
  resv_area_a: assert property (dbg_req.valid && dbg_req.addr >= 16'hfc00
    |=> dbg_denied ##0 flash_cmd.cmd == fsag_pkg::FSAG_CMD_NONE) else $error("reserved hit");
  ram_write_a: assert property (cw && !program_store_control[0]
    |=> cpu_ram_write && flash_cmd.cmd == fsag_pkg::FSAG_CMD_NONE) else $error("ram write");
  limit_block_a: assert property (cv && cpu_req.pc >= access_limit_address
    && cpu_req.addr < access_limit_address && !program_store_control[2]
    && (cpu_req.code_read || !cpu_req.write || program_store_control[0])
    |=> cpu_denied) else $error("limit passed");
  sec_erase_a: assert property (cw && program_store_control[2:0] == 3'h3
    && cpu_req.addr[15:9] == 7'h7d |=> flash_cmd.cmd != fsag_pkg::FSAG_CMD_PAGE_ERASE)
    else $error("lock page erased");
  full_erase_c: cover property (de && lk && !lock_we_byte[7]);
  rd_lock_c: cover property (dr && !lock_rd_byte[blk]);
  limit_c: cover property (cv && cpu_req.addr < access_limit_address);
endmodule
bind fsag_guard fsag_guard_monitor fsag_guard_monitor_inst (.mclk, .reset_n, .sfr_wr,
  .sfr_addr, .sfr_wdata, .dbg_req, .cpu_req, .lock_we_byte, .lock_rd_byte,
  .program_store_control, .access_limit_address, .flash_cmd, .dbg_rdata, .dbg_denied,
  .cpu_denied, .cpu_ram_write);

/* fsag_flash_model.sv */
`timescale 1ns/1ps
module fsag_flash_model (
  input wire logic mclk,
  input wire logic [15:0] addr,
  input wire fsag_pkg::fsag_flash_s flash_cmd,
  output logic [7:0] flash_rdata,
  output logic [7:0] lock_we_byte,
  output logic [7:0] lock_rd_byte
);
  // Array content is a fixed pattern so read data follows from the address.
  assign flash_rdata = addr[7:0] ^ 8'h5a;
  initial begin
    lock_we_byte = 8'hff;
    lock_rd_byte = 8'hff;
  end
  always @(posedge mclk) begin
    if (flash_cmd.cmd == fsag_pkg::FSAG_CMD_FULL_ERASE ||
        (flash_cmd.cmd == fsag_pkg::FSAG_CMD_PAGE_ERASE && flash_cmd.addr[15:9] == 7'h7d)) begin
      lock_we_byte <= 8'hff;
      lock_rd_byte <= 8'hff;
    end else if (flash_cmd.cmd == fsag_pkg::FSAG_CMD_PROGRAM && !flash_cmd.scratch) begin
      // Programming only clears bits, as on erased flash.
      if (flash_cmd.addr == 16'hfbfe) lock_we_byte <= lock_we_byte & flash_cmd.data;
      if (flash_cmd.addr == 16'hfbff) lock_rd_byte <= lock_rd_byte & flash_cmd.data;
    end
  end
endmodule

/* test_flash_security_access_guard.sv */
`timescale 1ns/1ps
module test_flash_security_access_guard;
  logic mclk = 0, reset_n = 0, sfr_wr = 0, limit_wr = 0;
  logic [7:0] sfr_addr = 0, sfr_wdata = 0, dbg_rdata, cpu_rdata, program_store_control;
  logic [7:0] flash_rdata, lock_we_byte, lock_rd_byte;
  logic [15:0] limit_wdata = 0, access_limit_address;
  fsag_pkg::fsag_req_s dbg_req = '0;
  fsag_pkg::fsag_cpu_s cpu_req = '0;
  fsag_pkg::fsag_flash_s flash_cmd;
  logic dbg_denied, cpu_denied, cpu_ram_write, dbg_done, cpu_done;
  int failures = 0, tests_run = 0, cycles = 0;
  wire [15:0] faddr = dbg_req.valid ? dbg_req.addr : cpu_req.addr;
  fsag_guard fsag_guard_inst (.mclk, .reset_n, .sfr_wr, .sfr_addr, .sfr_wdata, .limit_wr,
    .limit_wdata, .dbg_req, .cpu_req, .flash_rdata, .lock_we_byte, .lock_rd_byte,
    .program_store_control, .access_limit_address, .flash_cmd, .dbg_rdata, .dbg_done,
    .dbg_denied, .cpu_done, .cpu_denied, .cpu_ram_write, .cpu_rdata);
  fsag_flash_model fsag_flash_model_inst (.mclk, .addr(faddr), .flash_cmd, .flash_rdata,
    .lock_we_byte, .lock_rd_byte);
  always #25 mclk = ~mclk;
  task stop_test();
    $display("tests_run %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      stop_test();
    end
  end
  task chk(input string n, input logic [15:0] e, input logic [15:0] s);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask
  task dbg(input logic [1:0] op, input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk) dbg_req <= '{1'b1, fsag_pkg::fsag_op_e'(op), a, d};
    @(posedge mclk) dbg_req <= '0;
    #1;
  endtask
  task cpu(input logic [15:0] pc, input logic [15:0] a, input logic w, input logic [7:0] d);
    @(posedge mclk) cpu_req <= '{1'b1, 1'b0, pc, w, a, d};
    @(posedge mclk) cpu_req <= '0;
    #1;
  endtask
  task sfr(input logic [7:0] d);
    @(posedge mclk) {sfr_wr, sfr_addr, sfr_wdata} <= {1'b1, 8'h8f, d};
    @(posedge mclk) sfr_wr <= 0;
    #1;
  endtask
  task t_regs();
    chk("control", 16'h00, program_store_control);
    chk("limit", 16'h0000, access_limit_address);
    sfr(8'hff);
    chk("control", 16'h07, program_store_control);
  endtask
  task t_fw();
    sfr(8'h00);
    cpu(16'h0, 16'h1000, 1, 8'h33);
    chk("ram", 1, cpu_ram_write);
    chk("cmd", 0, flash_cmd.cmd);
    sfr(8'h01);
    cpu(16'h0, 16'h1000, 1, 8'h33);
    chk("cmd", 1, flash_cmd.cmd);
    chk("data", 16'h33, flash_cmd.data);
    sfr(8'h03);
    cpu(16'h0, 16'h1234, 1, 8'h00);
    chk("cmd", 2, flash_cmd.cmd);
    cpu(16'h0, 16'hfa10, 1, 8'h00);
    chk("sec erase", 0, flash_cmd.cmd == 2);
    sfr(8'h05);
    cpu(16'h0, 16'h0010, 1, 8'h44);
    chk("scratch", 1, flash_cmd.scratch);
  endtask
  task t_dbg();
    dbg(2'h1, 16'hfbff, 8'hfe);
    dbg(2'h0, 16'h0010, 8'h00);
    chk("denied", 1, dbg_denied);
    chk("rdata", 16'h00, dbg_rdata);
    dbg(2'h0, 16'h2010, 8'h00);
    chk("rdata", 16'h4a, dbg_rdata);
    dbg(2'h0, 16'hfbff, 8'h00);
    chk("rdata", 16'ha5, dbg_rdata);
    cpu(16'h0, 16'h0010, 0, 8'h00);
    chk("cpu rdata", 16'h4a, cpu_rdata);
    dbg(2'h1, 16'hfbfe, 8'h7e);
    dbg(2'h1, 16'h0020, 8'h11);
    chk("denied", 1, dbg_denied);
    chk("cmd", 0, flash_cmd.cmd);
    dbg(2'h2, 16'hfa00, 8'h00);
    chk("denied", 1, dbg_denied);
    dbg(2'h2, 16'hfbfe, 8'h00);
    chk("cmd", 4, flash_cmd.cmd);
    dbg(2'h2, 16'hfa00, 8'h00);
    chk("cmd", 2, flash_cmd.cmd);
    dbg(2'h0, 16'hfc00, 8'h00);
    chk("denied", 1, dbg_denied);
  endtask
  task t_limit();
    sfr(8'h00);
    @(posedge mclk) {limit_wr, limit_wdata} <= {1'b1, 16'h4000};
    @(posedge mclk) limit_wr <= 0;
    #1 chk("limit", 16'h4000, access_limit_address);
    cpu(16'h5000, 16'h1000, 0, 8'h00);
    chk("cpu denied", 1, cpu_denied);
    cpu(16'h1000, 16'h1000, 0, 8'h00);
    chk("cpu rdata", 16'h5a, cpu_rdata);
    cpu(16'h5000, 16'hfd00, 0, 8'h00);
    chk("cpu denied", 1, cpu_denied);
    @(posedge mclk) cpu_req <= '{1'b1, 1'b1, 16'h5000, 1'b0, 16'h1000, 8'h00};
    @(posedge mclk) cpu_req <= '0;
    #1 chk("code read denied", 1, cpu_denied);
    @(posedge mclk) begin
      dbg_req <= '{1'b1, fsag_pkg::FSAG_OP_READ, 16'h2010, 8'h00};
      cpu_req <= '{1'b1, 1'b0, 16'h1000, 1'b0, 16'h2010, 8'h00};
    end
    @(posedge mclk) begin
      dbg_req <= '0;
      cpu_req <= '0;
    end
    #1 chk("dbg done", 1, dbg_done);
    chk("dbg rdata", 16'h4a, dbg_rdata);
    chk("cpu done", 0, cpu_done);
  endtask
  initial begin
    repeat (3) @(posedge mclk);
    reset_n <= 1;
    #1 t_regs();
    t_fw();
    t_dbg();
    t_limit();
    stop_test();
  end
endmodule
